// ==== src/wdt_pkg.sv ====
package wdt_pkg;

  // Printed offsets are register indices; byte address is four times the index
  localparam logic [7:0] CTRL_INDEX = 8'h00;
  localparam logic [7:0] STATUS_INDEX = 8'h01;
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam logic [7:0] GUARD_ADDR = 8'h08;
  localparam logic [7:0] IRQ_STATUS_ADDR = 8'h0c;
  localparam logic [7:0] IRQ_MASK_ADDR = 8'h10;
  localparam logic [7:0] COUNT_ADDR = 8'h14;

  localparam int WINDOW_LSB = 4;
  localparam int PERIOD_LSB = 0;
  localparam int LOCK_BIT = 7;
  localparam int SYNC_BIT = 0;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [3:0] CODE_OFF = 4'h0;
  localparam logic [3:0] CODE_MAX = 4'hb;

  localparam logic [7:0] GUARD_KEY = 8'hd8;
  localparam logic [2:0] GUARD_WINDOW = 3'h4;

  localparam int IRQ_TIMEOUT = 0;
  localparam int IRQ_EARLY = 1;
  localparam int IRQ_SYNC_DONE = 2;
  localparam int IRQ_WIDTH = 3;

  localparam int PCLK_PERIOD_NS = 50;
  localparam int TICK_PERIOD_US = 1000;
  localparam int TICK_CYCLES = TICK_PERIOD_US * 1000 / PCLK_PERIOD_NS;
  localparam int HANDOFF_TICKS = 2;

  localparam int COUNT_WIDTH = 14;
  localparam logic [13:0] BASE_TICKS = 14'h0008;

  typedef enum logic [3:0] {
    ST_OFF = 4'b0001,
    ST_ARM = 4'b0010,
    ST_CLOSED = 4'b0100,
    ST_OPEN = 4'b1000
  } wd_state_t;

  // Code 1 gives 8 ticks, doubling per step up to 8192; reserved codes clamp
  function automatic logic [13:0] decode_ticks(input logic [3:0] code);
    logic [3:0] step;
    step = (code > CODE_MAX) ? CODE_MAX : code;
    if (step == CODE_OFF) begin
      decode_ticks = 14'h0000;
    end else begin
      decode_ticks = BASE_TICKS << (step - 4'h1);
    end
  endfunction : decode_ticks

endpackage : wdt_pkg

// ==== src/tick_divider.sv ====
module tick_divider #(
  parameter int DIV = wdt_pkg::TICK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  output logic tick
);
  localparam int W = $clog2(DIV);
  logic [W-1:0] count;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
      tick <= 1'b0;
    end else if (count == W'(DIV - 1)) begin
      count <= '0;
      tick <= 1'b1;
    end else begin
      count <= count + 1'b1;
      tick <= 1'b0;
    end
  end
endmodule : tick_divider

// ==== src/tick_handoff.sv ====
module tick_handoff (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic start,
  output logic busy,
  output logic done
);
  logic [1:0] seen;

  // A start while busy is dropped, not queued
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
      seen <= 2'h0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy <= 1'b1;
        seen <= 2'h0;
      end else if (busy && tick) begin
        if (seen == 2'(wdt_pkg::HANDOFF_TICKS - 1)) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          seen <= seen + 2'h1;
        end
      end
    end
  end
endmodule : tick_handoff

// ==== src/windowed_watchdog_registers.sv ====
// Contract
// - Non-zero window field in bits 7:4 selects windowed operation; zero means normal.
// - Window codes 1..B give closed times 8..8192 ticks; 0 off; above B reserved.
// - Non-zero period field in bits 3:0 turns the watchdog on; zero keeps it off.
// - Period codes 1..B give time-outs 8..8192 ticks, doubling; 0 off.
// - In windowed operation the period code sets the open window length.
// - While lock is one, control register writes are ignored.
// - Lock accepts only writes of one; cleared only in debug mode.
// - Non-zero period after boot load sets lock automatically.
// - Setting lock needs the protected-write unlock; unprotected attempts ignored.
// - Sync-pending rises right after a control write, held during transfer.
// - Sync-pending clears by hardware once transfer to tick domain ends.
// - Sync-pending readable anytime, read-only; status resets to zero.
// - Protected write succeeds only within four accesses after the unlock key.
// - System reset on missed time-out or kick inside the closed window.
// - A kick takes two to three ticks to sync; kicks meanwhile ignored. Here the handoff ends on the second tick seen, one to two tick periods.
// - Control reset value comes from the boot configuration fuse.
module windowed_watchdog_registers #(
  parameter int TICK_DIV = wdt_pkg::TICK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic kick_instruction,
  input wire logic debug_mode,
  input wire logic [7:0] boot_fuse_config,
  output logic system_reset,
  output logic irq
);

  localparam int IRQ_W = wdt_pkg::IRQ_WIDTH;
  typedef wdt_pkg::wd_state_t wd_state_alias_t;

  logic tick;
  logic [7:0] watchdog_control;
  logic [7:0] active_control;
  logic lock;
  logic boot_loaded;
  logic [2:0] guard_count;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] read_snapshot;
  logic [IRQ_W-1:0] events;
  logic sync_pending;
  logic ctrl_done;
  logic kick_busy;
  logic kick_done;
  logic ctrl_start;
  logic after_debug;
  wd_state_alias_t state;
  logic [13:0] remaining;
  logic fire_timeout;
  logic fire_early;

  tick_divider #(
    .DIV(TICK_DIV)
  ) u_tick_divider (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick)
  );

  // Control value handoff into the tick-rate logic
  tick_handoff u_ctrl_handoff (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick),
    .start(ctrl_start),
    .busy(sync_pending),
    .done(ctrl_done)
  );

  // Kicks pass through the same two-tick handoff; one in flight blocks the next
  tick_handoff u_kick_handoff (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick),
    .start(kick_instruction),
    .busy(kick_busy),
    .done(kick_done)
  );

  // Bus decode
  logic setup_phase;
  logic access_done;
  logic wr_done;
  logic rd_done;
  logic guard_open;
  logic ctrl_hit;
  logic status_hit;
  logic guard_hit;
  logic irq_status_hit;
  logic irq_mask_hit;
  logic count_hit;
  logic mapped;

  assign setup_phase = psel && !penable;
  assign access_done = psel && penable && pready;
  assign wr_done = access_done && pwrite;
  assign rd_done = access_done && !pwrite;
  assign guard_open = (guard_count != 3'h0);

  function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] target);
    addr_is = (addr == target);
  endfunction : addr_is

  assign ctrl_hit = addr_is(paddr, wdt_pkg::CTRL_ADDR);
  assign status_hit = addr_is(paddr, wdt_pkg::STATUS_ADDR);
  assign guard_hit = addr_is(paddr, wdt_pkg::GUARD_ADDR);
  assign irq_status_hit = addr_is(paddr, wdt_pkg::IRQ_STATUS_ADDR);
  assign irq_mask_hit = addr_is(paddr, wdt_pkg::IRQ_MASK_ADDR);
  assign count_hit = addr_is(paddr, wdt_pkg::COUNT_ADDR);
  assign mapped = ctrl_hit || status_hit || guard_hit || irq_status_hit
      || irq_mask_hit || count_hit;

  // A control write lands only when unlocked, guarded and not mid-transfer
  assign ctrl_start = (wr_done && ctrl_hit && guard_open && !lock && !sync_pending)
      || (!boot_loaded);

  // Zero-wait slave: ready is registered one cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup_phase;
      pslverr <= setup_phase && !mapped;
    end
  end

  logic [31:0] next_prdata;

  always_comb begin
    next_prdata = 32'h0000_0000;
    if (ctrl_hit) begin
      next_prdata[7:0] = watchdog_control;
    end else if (status_hit) begin
      next_prdata[7:0] = wdt_pkg::STATUS_RESET;
      next_prdata[wdt_pkg::LOCK_BIT] = lock;
      next_prdata[wdt_pkg::SYNC_BIT] = sync_pending;
    end else if (guard_hit) begin
      next_prdata[2:0] = guard_count;
    end else if (irq_status_hit) begin
      next_prdata[IRQ_W-1:0] = irq_status;
    end else if (irq_mask_hit) begin
      next_prdata[IRQ_W-1:0] = irq_mask;
    end else if (count_hit) begin
      next_prdata[13:0] = remaining;
      next_prdata[19:16] = state;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      read_snapshot <= '0;
    end else if (setup_phase) begin
      prdata <= pwrite ? 32'h0000_0000 : next_prdata;
      read_snapshot <= (!pwrite && irq_status_hit) ? irq_status : '0;
    end
  end

  // Fuse value is caught on the first edge after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_loaded <= 1'b0;
    end else begin
      boot_loaded <= 1'b1;
    end
  end

  // Guard window: the key opens four accesses; a guard write without the key shuts it, any other access uses one up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      guard_count <= 3'h0;
    end else if (wr_done && guard_hit) begin
      guard_count <= (pwdata[7:0] == wdt_pkg::GUARD_KEY) ? wdt_pkg::GUARD_WINDOW : 3'h0;
    end else if (access_done && guard_open) begin
      guard_count <= guard_count - 3'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_control <= 8'h00;
    end else if (!boot_loaded) begin
      watchdog_control <= boot_fuse_config;
    end else if (ctrl_start) begin
      watchdog_control <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock <= 1'b0;
    end else if (!boot_loaded) begin
      lock <= (boot_fuse_config[3:0] != wdt_pkg::CODE_OFF);
    end else if (wr_done && status_hit && guard_open) begin
      if (pwdata[wdt_pkg::LOCK_BIT]) begin
        lock <= 1'b1;
      end else if (debug_mode) begin
        lock <= 1'b0;
      end
    end
  end

  // Tick-rate copy of control, taken when the handoff completes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_control <= 8'h00;
    end else if (ctrl_done) begin
      active_control <= watchdog_control;
    end
  end

  // Timing core
  logic [3:0] window_code;
  logic [3:0] period_code;
  logic window_mode;
  logic running;

  assign window_code = active_control[7:wdt_pkg::WINDOW_LSB];
  assign period_code = active_control[wdt_pkg::WINDOW_LSB-1:wdt_pkg::PERIOD_LSB];
  assign window_mode = (window_code != wdt_pkg::CODE_OFF);
  assign running = (period_code != wdt_pkg::CODE_OFF);

  assign fire_early = (state == wdt_pkg::ST_CLOSED) && kick_done;
  assign fire_timeout = (state == wdt_pkg::ST_OPEN) && tick && !kick_done
      && (remaining <= 14'h0001);

  // Debug leaves the arm stage out after resuming; timing restarts in the open window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      after_debug <= 1'b0;
    end else if (debug_mode) begin
      after_debug <= 1'b1;
    end else if (state != wdt_pkg::ST_OFF) begin
      after_debug <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= wdt_pkg::ST_OFF;
      remaining <= 14'h0000;
    end else if (!running || debug_mode || ctrl_done || fire_early || fire_timeout) begin
      // New settings, halt or a fired reset restart from a clean count
      state <= wdt_pkg::ST_OFF;
      remaining <= 14'h0000;
    end else begin
      case (state)
        wdt_pkg::ST_OFF: begin
          if (window_mode && !after_debug) begin
            state <= wdt_pkg::ST_ARM;
          end else begin
            state <= wdt_pkg::ST_OPEN;
            remaining <= wdt_pkg::decode_ticks(period_code);
          end
        end
        wdt_pkg::ST_ARM: begin
          if (kick_done) begin
            state <= wdt_pkg::ST_CLOSED;
            remaining <= wdt_pkg::decode_ticks(window_code);
          end
        end
        wdt_pkg::ST_CLOSED: begin
          if (tick) begin
            if (remaining <= 14'h0001) begin
              state <= wdt_pkg::ST_OPEN;
              remaining <= wdt_pkg::decode_ticks(period_code);
            end else begin
              remaining <= remaining - 14'h0001;
            end
          end
        end
        wdt_pkg::ST_OPEN: begin
          if (kick_done && window_mode) begin
            state <= wdt_pkg::ST_CLOSED;
            remaining <= wdt_pkg::decode_ticks(window_code);
          end else if (kick_done) begin
            remaining <= wdt_pkg::decode_ticks(period_code);
          end else if (tick) begin
            remaining <= remaining - 14'h0001;
          end
        end
        default: begin
          state <= wdt_pkg::ST_OFF;
          remaining <= 14'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      system_reset <= 1'b0;
    end else begin
      system_reset <= fire_early || fire_timeout;
    end
  end

  // Interrupt flags: set beats the clear-on-read of the same bit
  always_comb begin
    events = '0;
    events[wdt_pkg::IRQ_TIMEOUT] = fire_timeout;
    events[wdt_pkg::IRQ_EARLY] = fire_early;
    events[wdt_pkg::IRQ_SYNC_DONE] = ctrl_done;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= '0;
    end else if (rd_done && irq_status_hit) begin
      // Only bits that were returned are cleared, so a late set is not lost
      irq_status <= (irq_status & ~read_snapshot) | events;
    end else begin
      irq_status <= irq_status | events;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= '0;
    end else if (wr_done && irq_mask_hit) begin
      irq_mask <= pwdata[IRQ_W-1:0];
    end
  end

  // Registered output lags the status bit by one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

endmodule : windowed_watchdog_registers

// ==== verif/wdt_properties.sv ====
module wdt_props #(
  parameter int TICK_DIV = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic debug_mode,
  input wire logic system_reset
);
  timeunit 1ns;
  timeprecision 1ns;
  logic setup;
  assign setup = psel && !penable;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_ready_follows: assert property (setup |=> pready)
    else $error("pready missing after setup");
  a_ready_only: assert property (!setup |=> !pready)
    else $error("pready without setup");
  a_unmapped_err: assert property (setup && paddr > 8'h14 |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (setup && paddr <= 8'h14 && paddr[1:0] == 2'h0 |=> !pslverr)
    else $error("mapped access refused");
  a_status_fields: assert property (
    setup && !pwrite && paddr == wdt_pkg::STATUS_ADDR |=> prdata[31:8] == 24'h0
    && prdata[6:1] == 6'h0) else $error("status reserved bits set");
  a_ctrl_width: assert property (
    setup && !pwrite && paddr == wdt_pkg::CTRL_ADDR |=> prdata[31:8] == 24'h0)
    else $error("control upper bits set");
  a_fire_pulse: assert property (system_reset |=> !system_reset [*8])
    else $error("reset pulse too long or too close");
  a_debug_quiet: assert property (debug_mode [*3] |-> !system_reset)
    else $error("reset while halted");
  a_rdata_hold: assert property (!psel |=> $stable(prdata))
    else $error("read data moved while idle");
  c_fire: cover property (system_reset);
  c_unmapped: cover property (setup && paddr > 8'h14);
  c_debug_write: cover property (debug_mode && setup && pwrite);
endmodule : wdt_props

bind windowed_watchdog_registers wdt_props #(.TICK_DIV(TICK_DIV)) props_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .debug_mode(debug_mode), .system_reset(system_reset));

// ==== verif/core_model.sv ====
module core_model (
  input wire logic pclk,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  output logic kick_instruction
);
  timeunit 1ns;
  timeprecision 1ns;
  logic err;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    kick_instruction = 1'b0;
  end
  // No fixed latency assumed: the access phase is held until pready is seen
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task gwr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, wdt_pkg::GUARD_ADDR, {24'h0, wdt_pkg::GUARD_KEY}, r);
    xfer(1'b1, a, d, r);
  endtask : gwr
  task kick();
    @(posedge pclk);
    kick_instruction <= 1'b1;
    @(posedge pclk);
    kick_instruction <= 1'b0;
  endtask : kick
endmodule : core_model

// ==== verif/windowed_watchdog_registers_bench.sv ====
module windowed_watchdog_registers_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk;
  logic presetn;
  logic debug_mode;
  logic [7:0] boot_fuse_config;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic kick_instruction;
  logic system_reset;
  logic irq;
  logic [31:0] q;
  int miscompares = 0;
  int tests_run = 0;
  int cyc = 0;
  // Short tick so a code 1 time-out is 64 clocks
  windowed_watchdog_registers #(.TICK_DIV(8)) uut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .kick_instruction(kick_instruction),
    .debug_mode(debug_mode), .boot_fuse_config(boot_fuse_config),
    .system_reset(system_reset), .irq(irq));
  core_model core (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .kick_instruction(kick_instruction));
  task close_out();
    if (miscompares == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task rd(input logic [7:0] a, input logic [31:0] e);
    core.xfer(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask : rd
  task wait_sync();
    int n;
    n = 0;
    q = 32'h1;
    while (q[0] !== 1'b0 && n < 100) begin
      core.xfer(1'b0, wdt_pkg::STATUS_ADDR, 32'h0, q);
      n++;
    end
    chk({31'h0, q[0]}, 32'h0);
  endtask : wait_sync
  // Pulse is sampled before the edge updates land, so it is seen once
  task see_rst(input int lo, input int hi, input logic want);
    int n;
    n = 0;
    while (system_reset !== 1'b1 && n < hi) begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, system_reset === 1'b1 && n >= lo}, {31'h0, want});
  endtask : see_rst
  task t_lock();
    rd(wdt_pkg::CTRL_ADDR, 32'h0b);
    wait_sync();
    rd(wdt_pkg::STATUS_ADDR, 32'h80);
    core.gwr(wdt_pkg::STATUS_ADDR, 32'h0);
    rd(wdt_pkg::STATUS_ADDR, 32'h80);
    core.gwr(wdt_pkg::CTRL_ADDR, 32'h1);
    rd(wdt_pkg::CTRL_ADDR, 32'h0b);
    debug_mode <= 1'b1;
    core.gwr(wdt_pkg::STATUS_ADDR, 32'h0);
    debug_mode <= 1'b0;
    rd(wdt_pkg::STATUS_ADDR, 32'h0);
    // The key still has accesses left here, so shut the guard first
    core.xfer(1'b1, wdt_pkg::GUARD_ADDR, 32'h0, q);
    core.xfer(1'b1, wdt_pkg::STATUS_ADDR, 32'h80, q);
    rd(wdt_pkg::STATUS_ADDR, 32'h0);
    core.xfer(1'b1, wdt_pkg::CTRL_ADDR, 32'h1, q);
    rd(wdt_pkg::CTRL_ADDR, 32'h0b);
    core.xfer(1'b1, wdt_pkg::GUARD_ADDR, 32'hd8, q);
    repeat (4) core.xfer(1'b0, wdt_pkg::STATUS_ADDR, 32'h0, q);
    core.xfer(1'b1, wdt_pkg::CTRL_ADDR, 32'h1, q);
    rd(wdt_pkg::CTRL_ADDR, 32'h0b);
    rd(8'h20, 32'h0);
    chk({31'h0, core.err}, 32'h1);
  endtask : t_lock
  task t_sync_kick();
    core.gwr(wdt_pkg::CTRL_ADDR, 32'h02);
    rd(wdt_pkg::STATUS_ADDR, 32'h01);
    core.gwr(wdt_pkg::CTRL_ADDR, 32'h03);
    wait_sync();
    rd(wdt_pkg::CTRL_ADDR, 32'h02);
    core.gwr(wdt_pkg::STATUS_ADDR, 32'h01);
    rd(wdt_pkg::STATUS_ADDR, 32'h00);
    repeat (6) begin
      core.kick();
      core.kick();
      see_rst(0, 60, 1'b0);
    end
  endtask : t_sync_kick
  task t_timeout();
    core.xfer(1'b1, wdt_pkg::IRQ_MASK_ADDR, 32'h7, q);
    core.gwr(wdt_pkg::CTRL_ADDR, 32'h01);
    wait_sync();
    // Drain earlier sync-done flags so the later irq check means the time-out
    core.xfer(1'b0, wdt_pkg::IRQ_STATUS_ADDR, 32'h0, q);
    chk(q, 32'h4);
    see_rst(40, 80, 1'b1);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    core.xfer(1'b0, wdt_pkg::IRQ_STATUS_ADDR, 32'h0, q);
    chk(q & 32'h1, 32'h1);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    core.xfer(1'b1, wdt_pkg::IRQ_MASK_ADDR, 32'h0, q);
    see_rst(0, 100, 1'b1);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
  endtask : t_timeout
  task t_window();
    core.gwr(wdt_pkg::CTRL_ADDR, 32'h11);
    wait_sync();
    core.kick();
    core.kick();
    see_rst(0, 40, 1'b0);
    core.kick();
    see_rst(0, 40, 1'b1);
    core.xfer(1'b0, wdt_pkg::IRQ_STATUS_ADDR, 32'h0, q);
    chk(q & 32'h2, 32'h2);
    repeat (4) @(posedge pclk);
    core.kick();
    repeat (100) @(posedge pclk);
    core.kick();
    see_rst(0, 60, 1'b0);
    see_rst(60, 100, 1'b1);
    core.gwr(wdt_pkg::CTRL_ADDR, 32'h00);
    wait_sync();
    core.kick();
    see_rst(0, 200, 1'b0);
  endtask : t_window
  // Second boot with an idle fuse: no lock, watchdog off
  task t_boot();
    boot_fuse_config <= 8'h00;
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    wait_sync();
    rd(wdt_pkg::STATUS_ADDR, 32'h00);
    rd(wdt_pkg::CTRL_ADDR, 32'h00);
  endtask : t_boot
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      close_out();
    end
  end
  initial begin
    presetn = 1'b0;
    debug_mode = 1'b0;
    boot_fuse_config = 8'h0b;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_lock();
    t_sync_kick();
    t_timeout();
    t_window();
    t_boot();
    close_out();
  end
endmodule : windowed_watchdog_registers_bench
